// [rtl/totalizer_pulse_output.sv]
// totalizer pulse output with wishbone register access
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module totalizer_pulse_output #(
    parameter int TOT_W     = 32,
    parameter int INC_W     = 16,
    parameter int MS_DIV    = pulse_out_pkg::MS_CYCLES,
    parameter int PEND_SIZE = pulse_out_pkg::PEND_MAX
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // wishbone classic slave
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [7:0]       adr_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [31:0]      dat_i,
    output logic      [31:0]      dat_o,
    output logic                  ack_o,
    // flow increments from the measurement side
    input  wire logic             inc_valid_i,
    input  wire logic [INC_W-1:0] vol_inc_i,
    input  wire logic [INC_W-1:0] std_inc_i,
    input  wire logic [INC_W-1:0] mass_inc_i,
    // pulse line, high turns the output transistor on
    output logic                  pulse_o,
    output logic                  pulse_overflow_error_o
);
    import pulse_out_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge_sel

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic        ack_ff;
    logic        nxt_ack;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        wr_en;
    logic        rd_en;

    logic [31:0] ctrl_ff;
    logic [31:0] nxt_ctrl;
    logic [31:0] weight_ff;
    logic [31:0] nxt_weight;
    logic [31:0] factor_ff;
    logic [31:0] nxt_factor;
    logic        clr_cmd;
    logic        conv_cmd;

    logic [TOT_W-1:0]  tot_ff [3];
    logic [TOT_W-1:0]  nxt_tot [3];
    logic [PEND_W-1:0] pend_ff;
    logic [PEND_W-1:0] nxt_pend;
    logic              err_ff;
    logic              nxt_err;
    logic              shaper_busy;

    // ack one cycle after the request, dropped the cycle after
    assign wr_en = cyc_i && stb_i && we_i && ack_ff;
    assign rd_en = cyc_i && stb_i && !we_i && !ack_ff;

    always_comb begin
        nxt_ack   = cyc_i && stb_i && !ack_ff;
        nxt_rdata = rdata_ff;
        if (rd_en) begin
            case (adr_i)
                ADDR_CTRL:    nxt_rdata = ctrl_ff;
                ADDR_WEIGHT:  nxt_rdata = weight_ff;
                ADDR_STATUS:  nxt_rdata = {30'h0000_0000, shaper_busy,
                                           err_ff};
                ADDR_PENDING: nxt_rdata = {{(32-PEND_W){1'b0}}, pend_ff};
                ADDR_FACTOR:  nxt_rdata = factor_ff;
                ADDR_TOT_VOL: nxt_rdata = 32'(tot_ff[SRC_VOL]);
                ADDR_TOT_STD: nxt_rdata = 32'(tot_ff[SRC_STD]);
                ADDR_TOT_MAS: nxt_rdata = 32'(tot_ff[SRC_MAS]);
                default:      nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff   <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    assign ack_o = ack_ff;
    assign dat_o = rdata_ff;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    assign clr_cmd  = wr_en && adr_i == ADDR_CMD && sel_i[0]
                      && dat_i[CMD_CLR_BIT];
    assign conv_cmd = wr_en && adr_i == ADDR_CMD && sel_i[0]
                      && dat_i[CMD_CONV_BIT];

    always_comb begin
        nxt_ctrl   = ctrl_ff;
        nxt_weight = weight_ff;
        nxt_factor = factor_ff;
        if (wr_en) begin
            case (adr_i)
                ADDR_CTRL:   nxt_ctrl   = merge_sel(ctrl_ff, dat_i, sel_i);
                ADDR_WEIGHT: nxt_weight = merge_sel(weight_ff, dat_i, sel_i);
                ADDR_FACTOR: nxt_factor = merge_sel(factor_ff, dat_i, sel_i);
                default:     nxt_ctrl   = ctrl_ff;
            endcase
        end
        nxt_ctrl[31:CTRL_EN_BIT+1] = '0;
        if (nxt_weight == 32'h0000_0000) begin
            nxt_weight = WEIGHT_RST;     // a zero weight would pulse forever
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff   <= CTRL_RST;
            weight_ff <= WEIGHT_RST;
            factor_ff <= FACTOR_RST;
        end else begin
            ctrl_ff   <= nxt_ctrl;
            weight_ff <= nxt_weight;
            factor_ff <= nxt_factor;
        end
    end

    // ------------------------------------------------------------
    // totals and pulse weighting
    // ------------------------------------------------------------
    logic [1:0]       src;
    logic             out_en;
    logic [TOT_W-1:0] resid_ff;
    logic [TOT_W-1:0] nxt_resid;
    logic [TOT_W-1:0] sel_inc;
    logic [TOT_W-1:0] sel_prod;
    logic [TOT_W+31:0] prod;
    logic             req;

    assign src    = (ctrl_ff[CTRL_SRC_LSB +: 2] == 2'b11)
                    ? SRC_VOL : ctrl_ff[CTRL_SRC_LSB +: 2];
    assign out_en = ctrl_ff[CTRL_EN_BIT];
    assign prod   = tot_ff[src] * factor_ff;
    assign sel_prod = prod[FACTOR_FRAC +: TOT_W];

    always_comb begin
        case (src)
            SRC_STD: sel_inc = TOT_W'(std_inc_i);
            SRC_MAS: sel_inc = TOT_W'(mass_inc_i);
            default: sel_inc = TOT_W'(vol_inc_i);
        endcase
    end

    // the residue queues at most one pulse per clock, far faster than any
    // pulse can leave, so a burst of large increments can overflow the pending store
    always_comb begin
        nxt_tot[SRC_VOL] = tot_ff[SRC_VOL];
        nxt_tot[SRC_STD] = tot_ff[SRC_STD];
        nxt_tot[SRC_MAS] = tot_ff[SRC_MAS];
        nxt_resid        = resid_ff;
        req              = 1'b0;
        if (inc_valid_i) begin
            nxt_tot[SRC_VOL] = tot_ff[SRC_VOL] + TOT_W'(vol_inc_i);
            nxt_tot[SRC_STD] = tot_ff[SRC_STD] + TOT_W'(std_inc_i);
            nxt_tot[SRC_MAS] = tot_ff[SRC_MAS] + TOT_W'(mass_inc_i);
        end
        if (conv_cmd) begin
            nxt_tot[src] = sel_prod;
            nxt_resid    = '0;
        end else if (err_ff || !out_en) begin
            nxt_resid = '0;
        end else begin
            if (resid_ff >= TOT_W'(weight_ff)) begin
                req       = 1'b1;
                nxt_resid = resid_ff - TOT_W'(weight_ff);
            end
            if (inc_valid_i) begin
                nxt_resid = nxt_resid + sel_inc;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tot_ff[SRC_VOL] <= '0;
            tot_ff[SRC_STD] <= '0;
            tot_ff[SRC_MAS] <= '0;
            resid_ff        <= '0;
        end else begin
            tot_ff[SRC_VOL] <= nxt_tot[SRC_VOL];
            tot_ff[SRC_STD] <= nxt_tot[SRC_STD];
            tot_ff[SRC_MAS] <= nxt_tot[SRC_MAS];
            resid_ff        <= nxt_resid;
        end
    end

    // ------------------------------------------------------------
    // pending store and overflow
    // ------------------------------------------------------------
    logic tick;
    logic take;
    logic ovf;

    assign take = (pend_ff != '0) && !shaper_busy && !err_ff
                  && out_en;
    assign ovf  = req && !take
                  && (pend_ff == PEND_W'(PEND_SIZE));

    always_comb begin
        nxt_pend = pend_ff;
        nxt_err  = err_ff;
        if (clr_cmd) begin
            nxt_err = 1'b0;
        end
        if (ovf) begin
            nxt_err  = 1'b1;
            nxt_pend = '0;
        end else if (err_ff || !out_en) begin
            nxt_pend = '0;
        end else begin
            case ({req, take})
                2'b10:   nxt_pend = pend_ff + 1'b1;
                2'b01:   nxt_pend = pend_ff - 1'b1;
                default: nxt_pend = pend_ff;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_ff <= '0;
            err_ff  <= 1'b0;
        end else begin
            pend_ff <= nxt_pend;
            err_ff  <= nxt_err;
        end
    end

    assign pulse_overflow_error_o = err_ff;

    // ------------------------------------------------------------
    // pulse timing
    // ------------------------------------------------------------
    ms_tick #(
        .DIV    (MS_DIV)
    ) u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (tick)
    );

    pulse_shaper u_shape (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (tick),
        .start_i (take),
        .abort_i (err_ff),
        .len_i   (len_ms(ctrl_ff[CTRL_LEN_LSB +: 3])),
        .busy_o  (shaper_busy),
        .pulse_o (pulse_o)
    );
endmodule : totalizer_pulse_output

// [rtl/pulse_out_pkg.sv]
// constants and register map of the totalizer pulse output
package pulse_out_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_WEIGHT  = 8'h04;
    localparam logic [7:0] ADDR_STATUS  = 8'h08;
    localparam logic [7:0] ADDR_PENDING = 8'h0c;
    localparam logic [7:0] ADDR_CMD     = 8'h10;
    localparam logic [7:0] ADDR_FACTOR  = 8'h14;
    localparam logic [7:0] ADDR_TOT_VOL = 8'h18;
    localparam logic [7:0] ADDR_TOT_STD = 8'h1c;
    localparam logic [7:0] ADDR_TOT_MAS = 8'h20;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_LEN_LSB = 2;
    localparam int CTRL_EN_BIT  = 5;
    localparam int CMD_CLR_BIT  = 0;
    localparam int CMD_CONV_BIT = 1;
    localparam int FACTOR_FRAC  = 16;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] WEIGHT_RST = 32'h0000_0001;
    localparam logic [31:0] FACTOR_RST = 32'h0001_0000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ     = 100_000_000;
    localparam int MS_PER_S   = 1000;
    localparam int MS_CYCLES  = CLK_HZ / MS_PER_S;
    localparam int PEND_MAX   = 4096;
    localparam int PEND_W     = 13;
    localparam int LEN_W      = 9;

    typedef enum logic [1:0] {
        SRC_VOL = 2'b00,
        SRC_STD = 2'b01,
        SRC_MAS = 2'b10
    } src_t;

    // unused codes fall back to the shortest length
    function automatic logic [LEN_W-1:0] len_ms(input logic [2:0] code);
        case (code)
            3'd0:    len_ms = 9'd20;
            3'd1:    len_ms = 9'd40;
            3'd2:    len_ms = 9'd60;
            3'd3:    len_ms = 9'd100;
            3'd4:    len_ms = 9'd260;
            3'd5:    len_ms = 9'd500;
            default: len_ms = 9'd20;
        endcase
    endfunction : len_ms
endpackage : pulse_out_pkg

// [rtl/ms_tick.sv]
// divider that gives a one-cycle pulse every millisecond
`timescale 1ns/100ps
module ms_tick #(
    parameter int DIV = 100_000
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      tick_o
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic          tick_ff;
    logic          nxt_tick;

    always_comb begin
        nxt_tick = (cnt_ff == CW'(DIV - 1));
        nxt_cnt  = nxt_tick ? '0 : cnt_ff + 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_o = tick_ff;
endmodule : ms_tick

// [rtl/pulse_shaper.sv]
// one pulse of a given length in ms followed by an equal idle gap
`timescale 1ns/100ps
module pulse_shaper
    import pulse_out_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             tick_i,
    input  wire logic             start_i,
    input  wire logic             abort_i,
    input  wire logic [LEN_W-1:0] len_i,
    output logic                  busy_o,
    output logic                  pulse_o
);
    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_HIGH = 2'b01,
        SH_GAP  = 2'b10
    } shape_t;

    shape_t           st_ff;
    shape_t           nxt_st;
    logic [LEN_W-1:0] cnt_ff;
    logic [LEN_W-1:0] nxt_cnt;
    logic [LEN_W-1:0] len_ff;
    logic [LEN_W-1:0] nxt_len;
    logic             out_ff;
    logic             nxt_out;

    // the length is latched at start so a mid-pulse change cannot cut it;
    // counting whole ticks may stretch each phase by up to one ms
    always_comb begin
        nxt_st  = st_ff;
        nxt_cnt = cnt_ff;
        nxt_len = len_ff;
        case (st_ff)
            SH_IDLE: begin
                if (start_i && !abort_i) begin
                    nxt_st  = SH_HIGH;
                    nxt_cnt = '0;
                    nxt_len = len_i;
                end
            end
            SH_HIGH: begin
                if (tick_i) begin
                    nxt_cnt = cnt_ff + 1'b1;
                    if (cnt_ff == len_ff) begin
                        nxt_st  = SH_GAP;
                        nxt_cnt = '0;
                    end
                end
            end
            SH_GAP: begin
                if (tick_i) begin
                    nxt_cnt = cnt_ff + 1'b1;
                    if (cnt_ff == len_ff) begin
                        nxt_st = SH_IDLE;
                    end
                end
            end
            default: nxt_st = SH_IDLE;
        endcase
        if (abort_i && st_ff == SH_HIGH) begin
            nxt_st  = SH_GAP;
            nxt_cnt = '0;
        end
        nxt_out = (nxt_st == SH_HIGH);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff  <= SH_IDLE;
            cnt_ff <= '0;
            len_ff <= '0;
            out_ff <= 1'b0;
        end else begin
            st_ff  <= nxt_st;
            cnt_ff <= nxt_cnt;
            len_ff <= nxt_len;
            out_ff <= nxt_out;
        end
    end

    assign busy_o  = (st_ff != SH_IDLE);
    assign pulse_o = out_ff;
endmodule : pulse_shaper

// [test/pulse_out_assertions.sv]
// port-level checks of the totalizer pulse output
`timescale 1ns/100ps
module pulse_out_assertions
    import pulse_out_pkg::*;
#(
    parameter int MS_DIV = 10
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    input wire logic        pulse_o,
    input wire logic        pulse_overflow_error_o
);
    // one cycle of slack each way for tick alignment
    localparam int MIN_T = 20 * MS_DIV - 1;
    localparam int MAX_T = 501 * MS_DIV + 1;
    logic [15:0] hi_ff, lo_ff, nxt_hi, nxt_lo;
    logic        clr;
    assign clr = cyc_i && stb_i && we_i && adr_i == ADDR_CMD
                 && sel_i[0] && dat_i[CMD_CLR_BIT];
    // the gap counter starts saturated so a first pulse is not flagged
    always_comb begin
        nxt_hi = pulse_o ? hi_ff + 16'h0001 : 16'h0000;
        nxt_lo = pulse_o ? 16'h0000 : lo_ff + {15'h0000, lo_ff != 16'hffff};
        if (rst_i) begin
            nxt_hi = 16'h0000;
            nxt_lo = 16'hffff;
        end
    end
    always_ff @(posedge clk_i) begin
        hi_ff <= nxt_hi;
        lo_ff <= nxt_lo;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_start;
        !pulse_o ##1 pulse_o;
    endsequence
    a_ack_after_req: assert property (s_req |=> ack_o)
        else $error("no ack after request");
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_has_req: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_err_line_idle: assert property (
        pulse_overflow_error_o ##1 pulse_overflow_error_o |-> !pulse_o)
        else $error("pulse line active during error");
    a_start_no_err: assert property (
        s_start |-> !pulse_overflow_error_o)
        else $error("pulse started during error");
    a_err_sticky: assert property (
        pulse_overflow_error_o && !clr |=> pulse_overflow_error_o)
        else $error("error dropped without clear");
    a_clear_drops_err: assert property (
        clr && ack_o |=> !pulse_overflow_error_o)
        else $error("error kept after clear");
    a_pulse_width: assert property (
        $fell(pulse_o) && !pulse_overflow_error_o
        |-> hi_ff >= MIN_T && hi_ff <= MAX_T)
        else $error("pulse width out of range");
    a_gap_width: assert property (s_start |-> lo_ff >= MIN_T)
        else $error("gap before pulse too short");
endmodule : pulse_out_assertions

bind totalizer_pulse_output pulse_out_assertions #(.MS_DIV(MS_DIV)) chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .ack_o(ack_o), .pulse_o(pulse_o),
    .pulse_overflow_error_o(pulse_overflow_error_o));

// [test/pulse_counter_model.sv]
// external counter input that reads the pulse line
`timescale 1ns/100ps
module pulse_counter_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        line_i,
    output logic      [15:0] count_o,
    output logic      [15:0] high_len_o
);
    logic        line_ff;
    logic [15:0] run_ff;
    // counts edges, as a real totaliser input does, not high cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_ff <= 1'b0;
            run_ff <= 16'h0000;
            count_o <= 16'h0000;
            high_len_o <= 16'h0000;
        end else begin
            line_ff <= line_i;
            run_ff <= line_i ? run_ff + 16'h0001 : 16'h0000;
            if (line_i && !line_ff)
                count_o <= count_o + 16'h0001;
            if (!line_i && line_ff)
                high_len_o <= run_ff;
        end
    end
endmodule : pulse_counter_model

// [test/tb_totalizer_pulse_output.sv]
// self-checking bench of the totalizer pulse output
`timescale 1ns/100ps
module tb_totalizer_pulse_output;
    import pulse_out_pkg::*;
    localparam int DIV = 10;
    localparam int LIMIT = 40000;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic        inc_valid_i, pulse_o, pulse_overflow_error_o;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o;
    logic [15:0] vol_inc_i, std_inc_i, mass_inc_i, cnt, hlen;
    logic [31:0] exp_q[$];
    logic [31:0] tot[3];
    int          lens[6] = '{20, 40, 60, 100, 260, 500};
    int          n_errors, checks, cycles, seed, base;

    totalizer_pulse_output #(.MS_DIV(DIV), .PEND_SIZE(8)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .inc_valid_i(inc_valid_i),
        .vol_inc_i(vol_inc_i), .std_inc_i(std_inc_i),
        .mass_inc_i(mass_inc_i), .pulse_o(pulse_o),
        .pulse_overflow_error_o(pulse_overflow_error_o));
    pulse_counter_model far (.clk_i(clk_i), .rst_i(rst_i),
        .line_i(pulse_o), .count_o(cnt), .high_len_o(hlen));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors++;
            summarize();
        end
    end
    always @(posedge clk_i)
        if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0)
            check(dat_o, exp_q.pop_front());

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic summarize();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0000_0000);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr
    task automatic inc(input logic [15:0] v, s, m);
        inc_valid_i <= 1'b1;
        vol_inc_i <= v;
        std_inc_i <= s;
        mass_inc_i <= m;
        @(posedge clk_i);
        inc_valid_i <= 1'b0;
        tot[0] += {16'h0000, v};
        tot[1] += {16'h0000, s};
        tot[2] += {16'h0000, m};
    endtask : inc
    function automatic logic [15:0] rnd();
        return 16'($random(seed));
    endfunction : rnd
    function automatic logic [31:0] ctrl(input int s, l, e);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[CTRL_SRC_LSB +: 2] = 2'(s);
        v[CTRL_LEN_LSB +: 3] = 3'(l);
        v[CTRL_EN_BIT] = e[0];
        return v;
    endfunction : ctrl

    initial begin
        seed = 57338;
        n_errors = 0;
        checks = 0;
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, inc_valid_i} = 4'h0;
        {adr_i, sel_i, dat_i} = '0;
        {vol_inc_i, std_inc_i, mass_inc_i} = '0;
        tot = '{3{32'h0000_0000}};
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADDR_CTRL, 32'h0000_0000);
        rd(ADDR_WEIGHT, 32'h0000_0001);
        rd(ADDR_FACTOR, 32'h0001_0000);
        rd(ADDR_STATUS, 32'h0000_0000);
        wr(8'h28, 32'hffff_ffff);
        rd(8'h28, 32'h0000_0000);
        // a zero weight is refused and falls back to one pulse per unit
        wr(ADDR_WEIGHT, 32'h0000_0000);
        rd(ADDR_WEIGHT, 32'h0000_0001);
        wr(ADDR_WEIGHT, 32'h0000_0004);
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_CTRL, ctrl(0, i, 1));
            base = cnt;
            inc(16'h0004, rnd(), rnd());
            idle((2 * lens[i] + 4) * DIV);
            check(32'(cnt - base), 32'h0000_0001);
            check(32'(hlen >= lens[i] * DIV - 1 && hlen <= (lens[i] + 1) * DIV + 1), 32'h0000_0001);
        end
        // disabling first clears the residue left by the other source
        wr(ADDR_WEIGHT, 32'h0000_0005);
        for (int s = 0; s < 3; s++) begin
            wr(ADDR_CTRL, ctrl(s, 0, 0));
            wr(ADDR_CTRL, ctrl(s, 0, 1));
            base = cnt;
            inc(s == 0 ? 16'h000a : 16'h0004, s == 1 ? 16'h000a : 16'h0004,
                s == 2 ? 16'h000a : 16'h0004);
            idle(8);
            rd(ADDR_PENDING, 32'h0000_0001);
            idle(1000);
            check(32'(cnt - base), 32'h0000_0002);
        end
        wr(ADDR_CTRL, ctrl(1, 0, 0));
        wr(ADDR_FACTOR, 32'h0002_0000);
        wr(ADDR_CMD, 32'h0000_0002);
        tot[1] = tot[1] * 2;
        wr(ADDR_WEIGHT, 32'h0000_0001);
        wr(ADDR_CTRL, ctrl(0, 0, 1));
        base = cnt;
        inc(16'h0014, rnd(), rnd());
        idle(40);
        check(32'(pulse_overflow_error_o), 32'h0000_0001);
        rd(ADDR_PENDING, 32'h0000_0000);
        inc(rnd(), rnd(), rnd());
        idle(600);
        check(32'(cnt - base), 32'h0000_0001);
        check(32'(pulse_o), 32'h0000_0000);
        wr(ADDR_CTRL, ctrl(0, 0, 0));
        check(32'(pulse_overflow_error_o), 32'h0000_0001);
        wr(ADDR_CMD, 32'h0000_0001);
        check(32'(pulse_overflow_error_o), 32'h0000_0000);
        wr(ADDR_CTRL, ctrl(0, 0, 1));
        base = cnt;
        inc(16'h0001, rnd(), rnd());
        idle(500);
        check(32'(cnt - base), 32'h0000_0001);
        for (int k = 0; k < 3; k++)
            rd(ADDR_TOT_VOL + 8'(4 * k), tot[k]);
        summarize();
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : idle
endmodule : tb_totalizer_pulse_output
